// ==== verilog/blit_misc_command_decoder.sv ====
// Decoder for the pad, head report, mailbox semaphore and store commands.
`timescale 1ns/1ps

module blit_misc_command_decoder (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire blit_misc_pkg::apb_addr_type PADDR,
    input wire blit_misc_pkg::dword_type PWDATA,
    output blit_misc_pkg::dword_type PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CMD_VALID,
    input wire blit_misc_pkg::dword_type CMD_DATA,
    input wire logic CMD_FROM_BATCH,
    input wire logic CMD_BATCH_SECURE,
    output logic CMD_READY,
    output logic PASS_VALID,
    output blit_misc_pkg::dword_type PASS_DATA,
    input wire logic PASS_READY,
    input wire logic PASS_RELEASE,
    input wire blit_misc_pkg::dword_type RING_HEAD,
    output logic RD_REQ,
    output blit_misc_pkg::dword_type RD_ADDR,
    output logic RD_IS_REG,
    input wire logic RD_ACK,
    input wire blit_misc_pkg::dword_type RD_DATA,
    output logic WR_REQ,
    output blit_misc_pkg::dword_type WR_ADDR,
    output blit_misc_pkg::dword_type WR_DATA,
    output logic WR_IS_REG,
    output logic WR_SNOOP,
    output logic WR_GLOBAL,
    input wire logic WR_ACK,
    output logic CTX_SWITCH_REQ,
    input wire logic CTX_ACK,
    output logic [blit_misc_pkg::TAG_W-1:0] STREAM_TAG
);
    import blit_misc_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    state_type state_q;
    cmd_type kind_q;
    cmd_type hdr_kind;
    dword_type hdr_q;
    dword_type dw1_q;
    logic nonsecure_q;
    logic cmd_ready_q;
    logic pass_valid_q;
    dword_type pass_data_q;
    logic release_q;
    logic rd_req_q;
    dword_type rd_addr_q;
    logic rd_is_reg_q;
    logic wr_req_q;
    dword_type wr_addr_q;
    dword_type wr_data_q;
    logic wr_is_reg_q;
    logic wr_snoop_q;
    logic wr_global_q;
    logic ctx_req_q;
    logic [TAG_W-1:0] tag_q;
    dword_type ctrl_q;
    dword_type head_addr_q;
    logic [15:0] waits_q;
    dword_type prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic take;
    logic sem_fail;
    dword_type status_word;
    dword_type read_mux;
    logic mapped;

    assign take = CMD_VALID && cmd_ready_q;
    assign sem_fail = (state_q == ST_READ) && RD_ACK && (kind_q == CMD_MBOX)
        && hdr_q[SEM_COMPARE_BIT] && !(RD_DATA > dw1_q);

    misc_header_decode u_decode (
        .header(CMD_DATA),
        .kind(hdr_kind)
    );

    // ------------------------------------------------------------------
    // Command sequencer
    // ------------------------------------------------------------------
    // Ready is dropped for every multi-cycle action so that nothing else
    // is fetched while a read, write or pass-through is outstanding.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= ST_IDLE;
            kind_q <= CMD_OTHER;
            hdr_q <= 32'h0000_0000;
            dw1_q <= 32'h0000_0000;
            nonsecure_q <= 1'b0;
            cmd_ready_q <= 1'b0;
            pass_valid_q <= 1'b0;
            pass_data_q <= 32'h0000_0000;
            rd_req_q <= 1'b0;
            rd_addr_q <= 32'h0000_0000;
            rd_is_reg_q <= 1'b0;
            wr_req_q <= 1'b0;
            wr_addr_q <= 32'h0000_0000;
            wr_data_q <= 32'h0000_0000;
            wr_is_reg_q <= 1'b0;
            wr_snoop_q <= 1'b0;
            wr_global_q <= 1'b0;
            ctx_req_q <= 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    cmd_ready_q <= 1'b1;
                    if (take) begin
                        hdr_q <= CMD_DATA;
                        kind_q <= hdr_kind;
                        nonsecure_q <= CMD_FROM_BATCH && !CMD_BATCH_SECURE;
                        case (hdr_kind)
                            CMD_PAD: state_q <= ST_IDLE;
                            CMD_HEAD: begin
                                wr_req_q <= 1'b1;
                                wr_addr_q <= head_addr_q;
                                wr_data_q <= RING_HEAD;
                                wr_is_reg_q <= 1'b0;
                                wr_snoop_q <= 1'b1;
                                wr_global_q <= 1'b1;
                                cmd_ready_q <= 1'b0;
                                state_q <= ST_WRITE;
                            end
                            CMD_MBOX, CMD_STORE: state_q <= ST_DW1;
                            default: begin
                                pass_valid_q <= 1'b1;
                                pass_data_q <= CMD_DATA;
                                cmd_ready_q <= 1'b0;
                                state_q <= ST_PASS;
                            end
                        endcase
                    end
                end
                ST_DW1: begin
                    if (take) begin
                        dw1_q <= CMD_DATA;
                        state_q <= ST_DW2;
                    end
                end
                ST_DW2: begin
                    if (take) begin
                        cmd_ready_q <= 1'b0;
                        if (kind_q == CMD_STORE) begin
                            // Three dwords in all, the default length.
                            rd_req_q <= 1'b1;
                            rd_addr_q <= {9'h000,
                                dw1_q[REG_ADDR_HI:REG_ADDR_LO],
                                2'b00};
                            rd_is_reg_q <= 1'b1;
                            wr_addr_q <= {CMD_DATA[MEM_ADDR_HI:MEM_ADDR_LO],
                                2'b00};
                            state_q <= ST_READ;
                        end else if (hdr_q[SEM_COMPARE_BIT]
                            || hdr_q[SEM_UPDATE_BIT]) begin
                            rd_req_q <= 1'b1;
                            rd_addr_q <= {CMD_DATA[MEM_ADDR_HI:MEM_ADDR_LO],
                                2'b00};
                            rd_is_reg_q <= hdr_q[SEM_REG_BIT];
                            state_q <= ST_READ;
                        end else begin
                            cmd_ready_q <= 1'b1;
                            state_q <= ST_IDLE;
                        end
                    end
                end
                ST_READ: begin
                    if (RD_ACK) begin
                        rd_req_q <= 1'b0;
                        if (kind_q == CMD_STORE) begin
                            wr_req_q <= 1'b1;
                            wr_data_q <= RD_DATA;
                            wr_is_reg_q <= 1'b0;
                            wr_snoop_q <= 1'b1;
                            wr_global_q <= hdr_q[STORE_GLOBAL_BIT]
                                && !nonsecure_q;
                            state_q <= ST_WRITE;
                        end else if (hdr_q[SEM_COMPARE_BIT]) begin
                            if (RD_DATA > dw1_q) begin
                                cmd_ready_q <= 1'b1;
                                state_q <= ST_IDLE;
                            end else if (ctrl_q[CTRL_CTX_EN_BIT]) begin
                                ctx_req_q <= 1'b1;
                                state_q <= ST_CTX;
                            end else begin
                                rd_req_q <= 1'b1;
                            end
                        end else begin
                            wr_req_q <= 1'b1;
                            wr_addr_q <= rd_addr_q;
                            wr_data_q <= RD_DATA + 32'h0000_0001;
                            wr_is_reg_q <= rd_is_reg_q;
                            wr_snoop_q <= !rd_is_reg_q;
                            wr_global_q <= 1'b1;
                            state_q <= ST_WRITE;
                        end
                    end
                end
                ST_WRITE: begin
                    if (WR_ACK) begin
                        wr_req_q <= 1'b0;
                        cmd_ready_q <= 1'b1;
                        state_q <= ST_IDLE;
                    end
                end
                ST_CTX: begin
                    // The wait is polled again once the switch is granted.
                    if (CTX_ACK) begin
                        ctx_req_q <= 1'b0;
                        rd_req_q <= 1'b1;
                        state_q <= ST_READ;
                    end
                end
                ST_PASS: begin
                    if (pass_valid_q) begin
                        if (PASS_READY) begin
                            pass_valid_q <= 1'b0;
                            cmd_ready_q <= 1'b1;
                        end
                    end else if (release_q) begin
                        state_q <= ST_IDLE;
                    end else if (take) begin
                        pass_valid_q <= 1'b1;
                        pass_data_q <= CMD_DATA;
                        cmd_ready_q <= 1'b0;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                    cmd_ready_q <= 1'b0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Pass-through release
    // ------------------------------------------------------------------
    // A release that lands in the very cycle of the clear is kept.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            release_q <= 1'b0;
        end else if (PASS_RELEASE) begin
            release_q <= 1'b1;
        end else if (state_q == ST_PASS && !pass_valid_q) begin
            release_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Stream tag and wait statistics
    // ------------------------------------------------------------------
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tag_q <= TAG_RESET;
        end else if (state_q == ST_IDLE && take && hdr_kind == CMD_PAD
            && CMD_DATA[TAG_EN_BIT]) begin
            tag_q <= CMD_DATA[TAG_W-1:0];
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            waits_q <= 16'h0000;
        end else if (sem_fail) begin
            waits_q <= waits_q + 16'h0001;
        end
    end

    // ------------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------------
    // Read data is captured in the setup cycle, so every access finishes
    // without wait states.
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[STAT_STATE_LO +: 3] = state_q;
        status_word[STAT_CTX_BIT] = ctx_req_q;
        status_word[STAT_BUSY_BIT] = (state_q != ST_IDLE);
        status_word[STAT_WAITS_LO +: 16] = waits_q;
        mapped = 1'b1;
        read_mux = 32'h0000_0000;
        case (PADDR)
            CTRL_OFS: read_mux = ctrl_q;
            STATUS_OFS: read_mux = status_word;
            TAG_OFS: read_mux = {10'h000, tag_q};
            HEAD_ADDR_OFS: read_mux = head_addr_q;
            default: mapped = 1'b0;
        endcase
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
            pready_q <= 1'b0;
        end else begin
            pready_q <= 1'b1;
            if (PSEL && !PENABLE) begin
                prdata_q <= PWRITE ? 32'h0000_0000 : read_mux;
                pslverr_q <= !mapped;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctrl_q <= CTRL_RESET;
            head_addr_q <= HEAD_ADDR_RESET;
        end else if (PSEL && PENABLE && PWRITE && pready_q) begin
            if (PADDR == CTRL_OFS) begin
                ctrl_q <= PWDATA;
            end
            if (PADDR == HEAD_ADDR_OFS) begin
                head_addr_q <= {PWDATA[MEM_ADDR_HI:MEM_ADDR_LO], 2'b00};
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;
    assign CMD_READY = cmd_ready_q;
    assign PASS_VALID = pass_valid_q;
    assign PASS_DATA = pass_data_q;
    assign RD_REQ = rd_req_q;
    assign RD_ADDR = rd_addr_q;
    assign RD_IS_REG = rd_is_reg_q;
    assign WR_REQ = wr_req_q;
    assign WR_ADDR = wr_addr_q;
    assign WR_DATA = wr_data_q;
    assign WR_IS_REG = wr_is_reg_q;
    assign WR_SNOOP = wr_snoop_q;
    assign WR_GLOBAL = wr_global_q;
    assign CTX_SWITCH_REQ = ctx_req_q;
    assign STREAM_TAG = tag_q;

endmodule : blit_misc_command_decoder

// ==== verilog/blit_misc_pkg.sv ====
// Shared constants and types of the miscellaneous command decoder.
package blit_misc_pkg;

    typedef logic [31:0] dword_type;
    typedef logic [11:0] apb_addr_type;

    // ------------------------------------------------------------------
    // Header layout
    // ------------------------------------------------------------------
    localparam int CLASS_HI = 31;
    localparam int CLASS_LO = 29;
    localparam int OP_HI = 28;
    localparam int OP_LO = 23;
    localparam logic [2:0] MISC_CLASS = 3'h0;
    localparam logic [5:0] OP_PAD = 6'h00;
    localparam logic [5:0] OP_HEAD = 6'h07;
    localparam logic [5:0] OP_MBOX = 6'h16;
    localparam logic [5:0] OP_STORE = 6'h24;
    localparam int TAG_EN_BIT = 22;
    localparam int TAG_W = 22;
    localparam int SEM_UPDATE_BIT = 21;
    localparam int SEM_COMPARE_BIT = 20;
    localparam int SEM_REG_BIT = 18;
    localparam int STORE_GLOBAL_BIT = 22;
    localparam int LEN_HI = 7;
    localparam int LEN_LO = 0;
    localparam logic [7:0] STORE_LEN = 8'h01;
    localparam int REG_ADDR_HI = 22;
    localparam int REG_ADDR_LO = 2;
    localparam int MEM_ADDR_HI = 31;
    localparam int MEM_ADDR_LO = 2;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam apb_addr_type CTRL_OFS = 12'h000;
    localparam apb_addr_type STATUS_OFS = 12'h004;
    localparam apb_addr_type TAG_OFS = 12'h008;
    localparam apb_addr_type HEAD_ADDR_OFS = 12'h00c;
    localparam int CTRL_CTX_EN_BIT = 0;
    localparam dword_type CTRL_RESET = 32'h0000_0000;
    localparam dword_type HEAD_ADDR_RESET = 32'h0000_0000;
    localparam logic [TAG_W-1:0] TAG_RESET = 22'h00_0000;
    localparam int STAT_STATE_LO = 0;
    localparam int STAT_CTX_BIT = 3;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_WAITS_LO = 16;

    // ------------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_DW1 = 3'b001,
        ST_DW2 = 3'b011,
        ST_READ = 3'b010,
        ST_WRITE = 3'b110,
        ST_PASS = 3'b111,
        ST_CTX = 3'b101
    } state_type;

    typedef enum logic [2:0] {
        CMD_OTHER = 3'h0,
        CMD_PAD = 3'h1,
        CMD_HEAD = 3'h2,
        CMD_MBOX = 3'h3,
        CMD_STORE = 3'h4
    } cmd_type;

endpackage : blit_misc_pkg

// ==== verilog/misc_header_decode.sv ====
// Header classifier for the miscellaneous command decoder.
`timescale 1ns/1ps
module misc_header_decode (
    input wire blit_misc_pkg::dword_type header,
    output blit_misc_pkg::cmd_type kind
);
    import blit_misc_pkg::*;

    always_comb begin
        kind = CMD_OTHER;
        if (header[CLASS_HI:CLASS_LO] == MISC_CLASS) begin
            case (header[OP_HI:OP_LO])
                OP_PAD: kind = CMD_PAD;
                OP_HEAD: kind = CMD_HEAD;
                OP_MBOX: kind = CMD_MBOX;
                OP_STORE: kind = CMD_STORE;
                default: kind = CMD_OTHER;
            endcase
        end
    end

endmodule : misc_header_decode

// ==== test/cmd_mem_model.sv ====
// Memory and register responder standing behind the decoder.
`timescale 1ns/1ps
module cmd_mem_model (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic rd_req,
    input wire logic wr_req,
    input wire logic ctx_req,
    input wire blit_misc_pkg::dword_type rd_value,
    input wire logic [7:0] delay,
    output logic rd_ack,
    output logic wr_ack,
    output logic ctx_ack,
    output blit_misc_pkg::dword_type rd_data
);
    import blit_misc_pkg::*;
    logic [7:0] rc_q;
    logic [7:0] wc_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rc_q <= 8'h00;
            rd_ack <= 1'b0;
            rd_data <= 32'h0;
        end else begin
            rd_ack <= 1'b0;
            rc_q <= 8'h00;
            // Read data is only valid with the ack, so it toggles elsewhere.
            rd_data <= ~rd_data;
            if (rd_req && !rd_ack) begin
                rc_q <= rc_q + 8'h01;
                if (rc_q >= delay) begin
                    rd_ack <= 1'b1;
                    rd_data <= rd_value;
                end
            end
        end
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wc_q <= 8'h00;
            wr_ack <= 1'b0;
            ctx_ack <= 1'b0;
        end else begin
            wc_q <= (wr_req && !wr_ack) ? wc_q + 8'h01 : 8'h00;
            wr_ack <= wr_req && !wr_ack && wc_q >= delay;
            ctx_ack <= ctx_req && !ctx_ack;
        end
    end
endmodule : cmd_mem_model

// ==== test/blit_misc_command_decoder_assertions.sv ====
// Concurrent checks on the decoder's command and memory ports.
`timescale 1ns/1ps
module blit_misc_command_decoder_assertions (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic CMD_VALID,
    input wire blit_misc_pkg::dword_type CMD_DATA,
    input wire logic CMD_FROM_BATCH,
    input wire logic CMD_BATCH_SECURE,
    input wire logic CMD_READY,
    input wire logic PASS_VALID,
    input wire blit_misc_pkg::dword_type PASS_DATA,
    input wire logic PASS_RELEASE,
    input wire blit_misc_pkg::dword_type RING_HEAD,
    input wire logic RD_REQ,
    input wire blit_misc_pkg::dword_type RD_ADDR,
    input wire logic RD_IS_REG,
    input wire logic RD_ACK,
    input wire blit_misc_pkg::dword_type RD_DATA,
    input wire logic WR_REQ,
    input wire blit_misc_pkg::dword_type WR_ADDR,
    input wire blit_misc_pkg::dword_type WR_DATA,
    input wire logic WR_SNOOP,
    input wire logic WR_GLOBAL,
    input wire logic WR_ACK,
    input wire logic [blit_misc_pkg::TAG_W-1:0] STREAM_TAG
);
    import blit_misc_pkg::*;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    logic [1:0] left_q;
    logic pass_q;
    logic store_q;
    logic glob_q;
    dword_type reg_q;
    dword_type mem_q;
    wire take = CMD_VALID && CMD_READY;
    wire hdr = take && left_q == 2'h0 && !pass_q;
    wire misc = CMD_DATA[31:29] == MISC_CLASS;
    wire [5:0] op = CMD_DATA[28:23];
    wire multi = misc && (op == OP_MBOX || op == OP_STORE);
    wire known = multi || (misc && (op == OP_PAD || op == OP_HEAD));
    // Tracks header versus payload so that payload is never decoded.
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            left_q <= 2'h0;
            pass_q <= 1'b0;
            store_q <= 1'b0;
            glob_q <= 1'b0;
            reg_q <= 32'h0;
            mem_q <= 32'h0;
        end else begin
            if (hdr && multi) left_q <= 2'h2;
            else if (take && left_q != 2'h0) left_q <= left_q - 2'h1;
            if (hdr && !known) pass_q <= 1'b1;
            else if (PASS_RELEASE) pass_q <= 1'b0;
            if (hdr && misc && op == OP_STORE) store_q <= 1'b1;
            else if (WR_REQ && WR_ACK) store_q <= 1'b0;
            if (hdr) glob_q <= CMD_DATA[22]
                && !(CMD_FROM_BATCH && !CMD_BATCH_SECURE);
            if (take && left_q == 2'h2) reg_q <= CMD_DATA;
            if (take && left_q == 2'h1) mem_q <= CMD_DATA;
        end
    end
    property p_tag_load;
        hdr && misc && op == OP_PAD && CMD_DATA[22]
            |=> STREAM_TAG == $past(CMD_DATA[21:0]);
    endproperty
    a_tag_load: assert property (p_tag_load)
        else $error("tag not loaded by pad");
    property p_tag_keep;
        hdr && misc && op == OP_PAD && !CMD_DATA[22] |=> $stable(STREAM_TAG);
    endproperty
    a_tag_keep: assert property (p_tag_keep)
        else $error("tag changed by plain pad");
    property p_head;
        hdr && misc && op == OP_HEAD
            |=> WR_REQ && WR_SNOOP && WR_DATA == $past(RING_HEAD);
    endproperty
    a_head: assert property (p_head)
        else $error("head report write wrong");
    property p_halt;
        RD_REQ || WR_REQ |-> !CMD_READY;
    endproperty
    a_halt: assert property (p_halt)
        else $error("stream accepted during access");
    property p_store_rd;
        take && left_q == 2'h1 && store_q
            |=> RD_REQ && RD_IS_REG && RD_ADDR == {9'h0, reg_q[22:2], 2'h0};
    endproperty
    a_store_rd: assert property (p_store_rd)
        else $error("store register read wrong");
    property p_store_wr;
        store_q && RD_REQ && RD_ACK |=> WR_REQ && WR_SNOOP
            && WR_DATA == $past(RD_DATA) && WR_ADDR == {mem_q[31:2], 2'h0};
    endproperty
    a_store_wr: assert property (p_store_wr)
        else $error("store memory write wrong");
    property p_global;
        store_q && WR_REQ |-> WR_GLOBAL == glob_q;
    endproperty
    a_global: assert property (p_global)
        else $error("store translation select wrong");
    property p_pass;
        hdr && !known |=> PASS_VALID ##0 PASS_DATA == $past(CMD_DATA);
    endproperty
    a_pass: assert property (p_pass)
        else $error("unknown header not forwarded");
endmodule : blit_misc_command_decoder_assertions

bind blit_misc_command_decoder blit_misc_command_decoder_assertions u_chk (.*);

// ==== test/blit_misc_command_decoder_tb.sv ====
// Self-checking bench for the miscellaneous command decoder.
`timescale 1ns/1ps
module blit_misc_command_decoder_tb;
    import blit_misc_pkg::*;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic CMD_VALID = 1'b0;
    logic CMD_FROM_BATCH = 1'b0;
    logic CMD_BATCH_SECURE = 1'b0;
    logic PASS_READY = 1'b1;
    logic PASS_RELEASE = 1'b0;
    logic ctx_seen = 1'b0;
    apb_addr_type PADDR = 12'h000;
    dword_type PWDATA = 32'h0;
    dword_type CMD_DATA = 32'h0;
    dword_type RING_HEAD = 32'h0000_4c40;
    dword_type rd_value = 32'h0;
    logic [7:0] dly = 8'h00;
    logic PREADY, PSLVERR, CMD_READY, PASS_VALID, RD_REQ, RD_IS_REG, RD_ACK;
    logic WR_REQ, WR_IS_REG, WR_SNOOP, WR_GLOBAL, WR_ACK, CTX_SWITCH_REQ;
    logic CTX_ACK, err;
    dword_type PRDATA, PASS_DATA, RD_ADDR, RD_DATA, WR_ADDR, WR_DATA, rv;
    logic [TAG_W-1:0] STREAM_TAG;
    int miscompares = 0;
    int compares = 0;
    dword_type ph [2] = '{32'h2000_0000, 32'h1100_0000};
    blit_misc_command_decoder dut (.*);
    cmd_mem_model mem (.clk(CLK), .rst_n(RST_N), .rd_req(RD_REQ),
        .wr_req(WR_REQ), .ctx_req(CTX_SWITCH_REQ), .rd_value(rd_value),
        .delay(dly), .rd_ack(RD_ACK), .wr_ack(WR_ACK), .ctx_ack(CTX_ACK),
        .rd_data(RD_DATA));
    always #2 CLK = ~CLK;
    always @(posedge CLK) if (CTX_SWITCH_REQ === 1'b1) ctx_seen = 1'b1;
    task automatic chk(input string n, input dword_type e, input dword_type g);
        compares++;
        if (g !== e) begin
            $display("mismatch %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask : chk
    task automatic apb(input logic w, input apb_addr_type a,
        input dword_type d);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= d;
        @(posedge CLK);
        PENABLE <= 1'b1;
        @(posedge CLK iff PREADY === 1'b1);
        rv = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        @(posedge CLK);
    endtask : apb
    // Valid stays up between calls so dwords can go back to back.
    task automatic send(input dword_type d);
        CMD_VALID <= 1'b1;
        CMD_DATA <= d;
        @(posedge CLK iff CMD_READY === 1'b1);
    endtask : send
    task automatic wr_chk(input dword_type a, input dword_type d,
        input logic [1:0] f);
        @(posedge CLK iff WR_REQ === 1'b1);
        chk("wr_addr", a, WR_ADDR);
        chk("wr_data", d, WR_DATA);
        chk("wr_space_snoop", {30'h0, f}, {30'h0, WR_IS_REG, WR_SNOOP});
    endtask : wr_chk
    task automatic finish_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20000) @(posedge CLK);
        miscompares++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge CLK);
        RST_N <= 1'b1;
        @(posedge CLK);
        apb(1'b1, STATUS_OFS, 32'hffff_ffff);
        apb(1'b0, STATUS_OFS, 32'h0);
        chk("status", 32'h0, rv);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk("ctrl", CTRL_RESET, rv);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        $display("test registers done");
        send(32'h006a_bcde);
        send(32'h0015_4321);
        CMD_VALID <= 1'b0;
        @(posedge CLK);
        chk("tag", 32'h002a_bcde, {10'h0, STREAM_TAG});
        apb(1'b0, TAG_OFS, 32'h0);
        chk("tag_reg", 32'h002a_bcde, rv);
        $display("test pad done");
        foreach (ph[i]) begin
            send(ph[i]);
            CMD_VALID <= 1'b0;
            @(posedge CLK iff PASS_VALID === 1'b1);
            chk("pass", ph[i], PASS_DATA);
            PASS_RELEASE <= 1'b1;
            @(posedge CLK);
            PASS_RELEASE <= 1'b0;
            repeat (3) @(posedge CLK);
        end
        $display("test forward done");
        apb(1'b1, HEAD_ADDR_OFS, 32'h0000_1003);
        send({MISC_CLASS, OP_HEAD, 23'h0});
        CMD_VALID <= 1'b0;
        wr_chk(32'h0000_1000, RING_HEAD, 2'b01);
        $display("test head done");
        for (int i = 0; i < 3; i++) begin
            dly <= 8'(3 * i);
            rd_value <= 32'hc0de_0000 + i;
            CMD_FROM_BATCH <= (i != 0);
            CMD_BATCH_SECURE <= (i == 2);
            send({MISC_CLASS, OP_STORE, 1'b1, 14'h0, STORE_LEN});
            send(32'h0000_2064 + 32'h100 * i);
            send(32'h0008_0010);
            CMD_VALID <= 1'b0;
            @(posedge CLK iff RD_REQ === 1'b1);
            chk("rd_addr", 32'h0000_2064 + 32'h100 * i, RD_ADDR);
            wr_chk(32'h0008_0010, rd_value, 2'b01);
            chk("global", {31'h0, i != 1}, {31'h0, WR_GLOBAL});
        end
        $display("test store done");
        for (int i = 0; i < 2; i++) begin
            rd_value <= 32'h5;
            send({MISC_CLASS, OP_MBOX, 23'h20_0001} | (i << 18));
            send(32'h0000_0009);
            send(32'h0000_3000);
            CMD_VALID <= 1'b0;
            wr_chk(32'h0000_3000, 32'h6, {i[0], ~i[0]});
        end
        $display("test signal done");
        for (int c = 1; c >= 0; c--) begin
            apb(1'b1, CTRL_OFS, c);
            ctx_seen = 1'b0;
            rd_value <= 32'ha;
            send({MISC_CLASS, OP_MBOX, 23'h10_0001});
            send(32'h0000_000a);
            send(32'h0000_3000);
            CMD_VALID <= 1'b0;
            repeat (20) @(posedge CLK);
            chk("ctx", c, {31'h0, ctx_seen});
            chk("stalled", 32'h0, {31'h0, CMD_READY});
            rd_value <= 32'hb;
            @(posedge CLK iff CMD_READY === 1'b1);
        end
        $display("test wait done");
        finish_test();
    end
endmodule : blit_misc_command_decoder_tb
